// *** rsi_consts.svh ***
`ifndef RSI_CONSTS_SVH
`define RSI_CONSTS_SVH

// Register byte offsets on the APB
`define RSI_OFF_CTRL 8'h00
`define RSI_OFF_IRQ_REQ 8'h04
`define RSI_OFF_IRQ_EN 8'h08
`define RSI_OFF_PRIO 8'h0c
`define RSI_OFF_EDGE0 8'h10
`define RSI_OFF_EDGE1 8'h14
`define RSI_OFF_EDGE2 8'h18
`define RSI_OFF_PDIR 8'h1c
`define RSI_OFF_POUT 8'h20
`define RSI_OFF_PULL 8'h24
`define RSI_OFF_SHIFT 8'h28
`define RSI_OFF_SLADDR 8'h2c
`define RSI_OFF_SMODE 8'h30
`define RSI_OFF_SBUS 8'h34
`define RSI_OFF_CPUCLK 8'h38
`define RSI_OFF_CLKOUT 8'h3c

// Control/status field positions
`define RSI_CTRL_STANDBY 0
`define RSI_STAT_FROM_STBY 1
`define RSI_STAT_RUN 2
`define RSI_STAT_LONG_OPT 3

// Reset values of the initialised registers
`define RSI_RST_BYTE 8'h00
`define RSI_RST_NIB 4'h0

// Stabilisation wait, in main oscillator periods
`define RSI_WAIT_LONG_PERIODS 131072
`define RSI_WAIT_SHORT_PERIODS 32768
// Clock cycles of clk per main oscillator period (clk is the oscillator)
`define RSI_CYC_PER_PERIOD 1

`endif

// *** rsi_pkg.sv ***
package rsi_pkg;
    // Sequencer states: running, held in reset, stabilisation wait
    typedef enum logic [1:0] {
        st_run,
        st_held,
        st_wait
    } rsi_state_e;
    typedef logic [7:0] rsi_byte_t;
    typedef logic [3:0] rsi_nib_t;
endpackage

// *** rsi_sync.sv ***
`timescale 1ns/10ps
// Two-stage synchroniser for an asynchronous level
module rsi_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic d,
    output logic q
);
    logic meta_reg; // First stage, read only by the second

    // Resolve metastability before any logic sees the level
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// *** rsi_wait_cnt.sv ***
`timescale 1ns/10ps
// Oscillator-stabilisation counter; done pulses once per started wait
module rsi_wait_cnt #(
    parameter int WIDTH = 18,
    parameter int TARGET = 131072
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    output logic done
);
    logic [WIDTH-1:0] count_reg; // Elapsed oscillator periods
    localparam logic [WIDTH-1:0] LAST = WIDTH'(TARGET - 1);

    if (TARGET < 1 || TARGET > (1 << WIDTH)) begin : g_chk
        $error("rsi_wait_cnt: TARGET does not fit WIDTH");
    end

    // Count only while running; dropping run restarts the wait
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
        end else if (!run || done) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Completion pulse, registered so it is glitch-free
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done <= 1'b0;
        end else begin
            done <= run && !done && (count_reg == LAST);
        end
    end
endmodule

// *** rsi_top.sv ***
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "rsi_consts.svh"
// Overview of operation
// R1: Standby reset and operating reset handled differently
// R2: Any reset clears all interrupt request flags
// R3: Any reset clears all interrupt enable flags
// R4: Any reset clears interrupt priority select
// R5: Any reset clears three external edge modes
// R6: Reset clears port direction, buffers off, latches
// R7: Reset clears pull-up selects, pull-ups off
// R8: Serial shift and address kept only from standby
// R9: Any reset clears serial operating mode
// R10: Any reset clears serial bus control
// R11: Any reset clears processor clock select
// R12: Any reset clears clock output mode
// R13: Wait long or short oscillator count before resuming
// R14: Oscillator-clocked counter gates program start
module rsi_top
    import rsi_pkg::*;
#(
    parameter logic LONG_WAIT_OPT = 1'b1,
    parameter int WAIT_LONG_CYC = `RSI_WAIT_LONG_PERIODS * `RSI_CYC_PER_PERIOD,
    parameter int WAIT_SHORT_CYC = `RSI_WAIT_SHORT_PERIODS * `RSI_CYC_PER_PERIOD,
    parameter int NUM_IRQ = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_n,
    input wire logic [NUM_IRQ-1:0] irq_event,
    output logic cpu_run,
    output logic [NUM_IRQ-1:0] irq_pending,
    output rsi_nib_t irq_priority_select,
    output rsi_nib_t ext_int0_edge_mode,
    output rsi_nib_t ext_int1_edge_mode,
    output rsi_nib_t ext_int2_edge_mode,
    output rsi_byte_t port_out_en,
    output rsi_byte_t port_out,
    output rsi_byte_t port_pullup_en,
    output rsi_byte_t serial_shift_reg,
    output rsi_byte_t serial_slave_addr,
    output rsi_byte_t serial_op_mode,
    output rsi_byte_t serial_bus_control,
    output rsi_nib_t cpu_clock_select,
    output rsi_nib_t clock_out_mode
);
    localparam int WAIT_CYC = LONG_WAIT_OPT ? WAIT_LONG_CYC : WAIT_SHORT_CYC;
    localparam int CNT_W = 18;

    if (NUM_IRQ < 1 || NUM_IRQ > 32) begin : g_chk_irq
        $error("rsi_top: NUM_IRQ must be 1 to 32");
    end
    if (WAIT_CYC < 1 || WAIT_CYC > (1 << CNT_W)) begin : g_chk_wait
        $error("rsi_top: wait count out of range");
    end

    // Address match for one register word
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    // True for any mapped register offset
    function automatic logic mapped(input logic [7:0] addr);
        return (addr[1:0] == 2'b00) && (addr <= `RSI_OFF_CLKOUT);
    endfunction

    rsi_state_e state_reg; // Sequencer state
    rsi_state_e state_next;
    logic pin_n_s; // Synchronised reset pin, low = asserted
    logic wait_done; // Stabilisation wait finished
    logic standby_reg; // Software has put the chip in standby
    logic from_stby_reg; // Latest pin reset seen in run arrived during standby
    logic init; // Apply the reset state this cycle
    logic setup; // APB setup phase
    logic wr_en; // APB write committed this edge
    logic [NUM_IRQ-1:0] irq_req_reg; // Sticky request flags
    logic [NUM_IRQ-1:0] irq_en_reg; // Per-source enables
    logic [31:0] rd_word; // Read mux output

    // Pin is asynchronous to clk, so pass it through two flops
    rsi_sync #(
        .RST_VAL(1'b1)
    ) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .d(reset_pin_n),
        .q(pin_n_s)
    );

    // Counter on the oscillator clock; runs only in the wait state
    rsi_wait_cnt #(
        .WIDTH(CNT_W),
        .TARGET(WAIT_CYC)
    ) u_wait (
        .clk(clk),
        .reset(reset),
        .run(state_reg == st_wait), // see R14
        .done(wait_done)
    );

    // Next state: hold while pin low, then wait, then run
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            st_run: begin
                if (!pin_n_s) begin
                    state_next = st_held;
                end
            end
            st_held: begin
                if (pin_n_s) begin
                    state_next = st_wait; // see R13
                end
            end
            st_wait: begin
                if (!pin_n_s) begin
                    state_next = st_held; // Pin pulsed again, restart
                end else if (wait_done) begin
                    state_next = st_run; // see R14
                end
            end
        endcase
    end

    // Power-up starts in the wait so the oscillator settles first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= st_wait;
            cpu_run <= 1'b0;
        end else begin
            state_reg <= state_next;
            cpu_run <= (state_next == st_run);
        end
    end

    assign init = (state_reg == st_held);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;

    // Record which kind of reset this is, at the assertion edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            from_stby_reg <= 1'b0;
        end else if (state_reg == st_run && !pin_n_s) begin
            from_stby_reg <= standby_reg; // see R1
        end
    end

    // Standby flag: set by software, left when a reset wakes the chip
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            standby_reg <= 1'b0;
        end else if (init) begin
            standby_reg <= 1'b0;
        end else if (wr_en && hit(paddr, `RSI_OFF_CTRL)) begin
            standby_reg <= pwdata[`RSI_CTRL_STANDBY];
        end
    end

    // Request flags; a new event beats a same-cycle clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_req_reg <= '0;
        end else if (init) begin
            irq_req_reg <= '0; // see R2
        end else begin
            irq_req_reg <= (irq_req_reg & ~((wr_en && hit(paddr, `RSI_OFF_IRQ_REQ))
                ? pwdata[NUM_IRQ-1:0] : '0)) | irq_event;
        end
    end

    // Interrupt enables start masked
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_en_reg <= '0;
        end else if (init) begin
            irq_en_reg <= '0; // see R3
        end else if (wr_en && hit(paddr, `RSI_OFF_IRQ_EN)) begin
            irq_en_reg <= pwdata[NUM_IRQ-1:0];
        end
    end

    // Pending view for the core; silent until the core runs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_pending <= '0;
        end else begin
            irq_pending <= cpu_run ? (irq_req_reg & irq_en_reg) : '0;
        end
    end

    // Priority and external edge modes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_priority_select <= `RSI_RST_NIB;
            ext_int0_edge_mode <= `RSI_RST_NIB;
            ext_int1_edge_mode <= `RSI_RST_NIB;
            ext_int2_edge_mode <= `RSI_RST_NIB;
        end else if (init) begin
            irq_priority_select <= `RSI_RST_NIB; // see R4
            ext_int0_edge_mode <= `RSI_RST_NIB; // see R5
            ext_int1_edge_mode <= `RSI_RST_NIB; // see R5
            ext_int2_edge_mode <= `RSI_RST_NIB; // see R5
        end else if (wr_en) begin
            if (hit(paddr, `RSI_OFF_PRIO)) begin
                irq_priority_select <= pwdata[3:0];
            end
            if (hit(paddr, `RSI_OFF_EDGE0)) begin
                ext_int0_edge_mode <= pwdata[3:0];
            end
            if (hit(paddr, `RSI_OFF_EDGE1)) begin
                ext_int1_edge_mode <= pwdata[3:0];
            end
            if (hit(paddr, `RSI_OFF_EDGE2)) begin
                ext_int2_edge_mode <= pwdata[3:0];
            end
        end
    end

    // Digital port: a direction bit of 1 turns its output buffer on
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            port_out_en <= `RSI_RST_BYTE;
            port_out <= `RSI_RST_BYTE;
            port_pullup_en <= `RSI_RST_BYTE;
        end else if (init) begin
            port_out_en <= `RSI_RST_BYTE; // see R6
            port_out <= `RSI_RST_BYTE; // see R6
            port_pullup_en <= `RSI_RST_BYTE; // see R7
        end else if (wr_en) begin
            if (hit(paddr, `RSI_OFF_PDIR)) begin
                port_out_en <= pwdata[7:0];
            end
            if (hit(paddr, `RSI_OFF_POUT)) begin
                port_out <= pwdata[7:0];
            end
            if (hit(paddr, `RSI_OFF_PULL)) begin
                port_pullup_en <= pwdata[7:0];
            end
        end
    end

    // Serial data: kept through a standby reset, zeroed otherwise
    // Zeroing is one legal pick for contents that are undefined
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            serial_shift_reg <= `RSI_RST_BYTE;
            serial_slave_addr <= `RSI_RST_BYTE;
        end else if (init) begin
            if (!from_stby_reg) begin
                serial_shift_reg <= `RSI_RST_BYTE; // see R8
                serial_slave_addr <= `RSI_RST_BYTE; // see R8
            end
        end else if (wr_en) begin
            if (hit(paddr, `RSI_OFF_SHIFT)) begin
                serial_shift_reg <= pwdata[7:0];
            end
            if (hit(paddr, `RSI_OFF_SLADDR)) begin
                serial_slave_addr <= pwdata[7:0];
            end
        end
    end

    // Serial control registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            serial_op_mode <= `RSI_RST_BYTE;
            serial_bus_control <= `RSI_RST_BYTE;
        end else if (init) begin
            serial_op_mode <= `RSI_RST_BYTE; // see R9
            serial_bus_control <= `RSI_RST_BYTE; // see R10
        end else if (wr_en) begin
            if (hit(paddr, `RSI_OFF_SMODE)) begin
                serial_op_mode <= pwdata[7:0];
            end
            if (hit(paddr, `RSI_OFF_SBUS)) begin
                serial_bus_control <= pwdata[7:0];
            end
        end
    end

    // Clock selection and clock output mode
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cpu_clock_select <= `RSI_RST_NIB;
            clock_out_mode <= `RSI_RST_NIB;
        end else if (init) begin
            cpu_clock_select <= `RSI_RST_NIB; // see R11
            clock_out_mode <= `RSI_RST_NIB; // see R12
        end else if (wr_en) begin
            if (hit(paddr, `RSI_OFF_CPUCLK)) begin
                cpu_clock_select <= pwdata[3:0];
            end
            if (hit(paddr, `RSI_OFF_CLKOUT)) begin
                clock_out_mode <= pwdata[3:0];
            end
        end
    end

    // Read mux; narrow registers sit in the low bits
    always_comb begin
        rd_word = '0;
        unique case (paddr)
            `RSI_OFF_CTRL: begin
                rd_word[`RSI_CTRL_STANDBY] = standby_reg;
                rd_word[`RSI_STAT_FROM_STBY] = from_stby_reg;
                rd_word[`RSI_STAT_RUN] = cpu_run;
                rd_word[`RSI_STAT_LONG_OPT] = LONG_WAIT_OPT;
            end
            `RSI_OFF_IRQ_REQ: rd_word[NUM_IRQ-1:0] = irq_req_reg;
            `RSI_OFF_IRQ_EN: rd_word[NUM_IRQ-1:0] = irq_en_reg;
            `RSI_OFF_PRIO: rd_word[3:0] = irq_priority_select;
            `RSI_OFF_EDGE0: rd_word[3:0] = ext_int0_edge_mode;
            `RSI_OFF_EDGE1: rd_word[3:0] = ext_int1_edge_mode;
            `RSI_OFF_EDGE2: rd_word[3:0] = ext_int2_edge_mode;
            `RSI_OFF_PDIR: rd_word[7:0] = port_out_en;
            `RSI_OFF_POUT: rd_word[7:0] = port_out;
            `RSI_OFF_PULL: rd_word[7:0] = port_pullup_en;
            `RSI_OFF_SHIFT: rd_word[7:0] = serial_shift_reg;
            `RSI_OFF_SLADDR: rd_word[7:0] = serial_slave_addr;
            `RSI_OFF_SMODE: rd_word[7:0] = serial_op_mode;
            `RSI_OFF_SBUS: rd_word[7:0] = serial_bus_control;
            `RSI_OFF_CPUCLK: rd_word[3:0] = cpu_clock_select;
            `RSI_OFF_CLKOUT: rd_word[3:0] = clock_out_mode;
            default: rd_word = '0; // Unmapped reads as zero
        endcase
    end

    // APB answer: one access cycle, decided in the setup cycle
    // Writes are refused whenever the next state is not run: held, wait except a cycle with wait_done and pin_n_s high, and a run cycle with pin_n_s low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !mapped(paddr) || (pwrite && state_next != st_run);
            prdata <= pwrite ? '0 : rd_word;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
    end
endmodule

// *** rsi_top_monitor.sv ***
`timescale 1ns/10ps
// Checker on the top ports; reset hold, wait length and APB errors
module rsi_top_monitor
    import rsi_pkg::*;
#(
    parameter logic LONG_WAIT_OPT = 1'b1,
    parameter int WAIT_LONG_CYC = 16,
    parameter int WAIT_SHORT_CYC = 8,
    parameter int NUM_IRQ = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reset_pin_n,
    input wire logic cpu_run,
    input wire logic [NUM_IRQ-1:0] irq_pending,
    input wire rsi_nib_t irq_priority_select,
    input wire rsi_nib_t ext_int0_edge_mode,
    input wire rsi_nib_t ext_int1_edge_mode,
    input wire rsi_nib_t ext_int2_edge_mode,
    input wire rsi_byte_t port_out_en,
    input wire rsi_byte_t port_out,
    input wire rsi_byte_t port_pullup_en,
    input wire rsi_byte_t serial_op_mode,
    input wire rsi_byte_t serial_bus_control,
    input wire rsi_nib_t cpu_clock_select,
    input wire rsi_nib_t clock_out_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Selected wait; the pin synchroniser adds a few cycles on top
    localparam int WAIT_CYC = LONG_WAIT_OPT ? WAIT_LONG_CYC : WAIT_SHORT_CYC;
    int wait_cnt; // Cycles since the pin was last seen low, while run is off
    // Counts the wait as seen at the pin; saturates to avoid wrap
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_cnt <= 0;
        end else if (!reset_pin_n || cpu_run) begin
            wait_cnt <= 0;
        end else if (wait_cnt < 1000000) begin
            wait_cnt <= wait_cnt + 1;
        end
    end
    // Six low samples leave room for the two sync stages
    sequence s_held;
        (!reset_pin_n) [*6];
    endsequence
    property p_irq; s_held |-> irq_pending == '0; endproperty
    property p_ips; s_held |-> irq_priority_select == 4'h0; endproperty
    property p_edge;
        s_held |-> (ext_int0_edge_mode | ext_int1_edge_mode | ext_int2_edge_mode) == 4'h0;
    endproperty
    property p_port; s_held |-> port_out_en == 8'h00 && port_out == 8'h00; endproperty
    property p_pull; s_held |-> port_pullup_en == 8'h00; endproperty
    property p_ser; s_held |-> (serial_op_mode | serial_bus_control) == 8'h00; endproperty
    property p_clk; s_held |-> (cpu_clock_select | clock_out_mode) == 4'h0; endproperty
    property p_stop; $fell(reset_pin_n) |-> ##[3:5] !cpu_run; endproperty
    property p_wait;
        $rose(cpu_run) |-> wait_cnt >= WAIT_CYC && wait_cnt <= WAIT_CYC + 8;
    endproperty
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt pending while reset held");
    a_ips: assert property (p_ips)
        else $error("priority select not cleared");
    a_edge: assert property (p_edge)
        else $error("edge mode not cleared");
    a_port: assert property (p_port)
        else $error("port direction or latch not cleared");
    a_pull: assert property (p_pull)
        else $error("pull-up select not cleared");
    a_ser: assert property (p_ser)
        else $error("serial mode or bus control not cleared");
    a_clk: assert property (p_clk)
        else $error("clock select or clock out mode not cleared");
    a_stop: assert property (p_stop)
        else $error("run not stopped by pin reset");
    a_wait: assert property (p_wait)
        else $error("stabilisation wait has wrong length");
    a_err: assert property (p_err)
        else $error("error answer without ready or with data");
    c_run: cover property ($rose(cpu_run));
    c_stop: cover property ($fell(cpu_run));
    c_err: cover property (pslverr);
endmodule

bind rsi_top rsi_top_monitor #(.LONG_WAIT_OPT(LONG_WAIT_OPT), .WAIT_LONG_CYC(WAIT_LONG_CYC),
    .WAIT_SHORT_CYC(WAIT_SHORT_CYC), .NUM_IRQ(NUM_IRQ)) rsi_top_monitor_inst (
    .clk(clk), .reset(reset), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .cpu_run(cpu_run), .irq_pending(irq_pending),
    .irq_priority_select(irq_priority_select), .ext_int0_edge_mode(ext_int0_edge_mode),
    .ext_int1_edge_mode(ext_int1_edge_mode), .ext_int2_edge_mode(ext_int2_edge_mode),
    .port_out_en(port_out_en), .port_out(port_out), .port_pullup_en(port_pullup_en),
    .serial_op_mode(serial_op_mode), .serial_bus_control(serial_bus_control),
    .cpu_clock_select(cpu_clock_select), .clock_out_mode(clock_out_mode));

// *** rsi_pin_model.sv ***
`timescale 1ns/10ps
// External reset source: pulls the active-low pin for a set length
module rsi_pin_model (
    input wire logic clk,
    input wire logic fire,
    input wire logic [7:0] low_len,
    output logic reset_pin_n
);
    logic [7:0] left_reg = 8'h00; // Low cycles still to drive
    // A new fire restarts the count, so long or short pulses are possible
    always_ff @(posedge clk) begin
        if (fire) begin
            left_reg <= low_len;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
    // Pin idles high; no pull-down ambiguity since it is always driven
    assign reset_pin_n = (left_reg == 8'h00);
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
`include "rsi_consts.svh"
module tb_top
    import rsi_pkg::*;
;
    localparam int WL = 16; // Shortened long wait
    logic clk, reset, psel, penable, pwrite, pready, pslverr, reset_pin_n, cpu_run, fire;
    logic [7:0] paddr, irq_event, irq_pending, low_len;
    logic [31:0] pwdata, prdata, rd;
    rsi_nib_t prio, em0, em1, em2, cpuclk, clkout;
    rsi_byte_t pen, pout, pull, sshift, sladdr, smode, sbus;
    logic err;
    int failures, checks_done, cycles, rel_cnt;
    rsi_top #(.LONG_WAIT_OPT(1'b1), .WAIT_LONG_CYC(WL), .WAIT_SHORT_CYC(8), .NUM_IRQ(8))
    rsi_top_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_pin_n(reset_pin_n), .irq_event(irq_event), .cpu_run(cpu_run),
        .irq_pending(irq_pending), .irq_priority_select(prio), .ext_int0_edge_mode(em0),
        .ext_int1_edge_mode(em1), .ext_int2_edge_mode(em2), .port_out_en(pen),
        .port_out(pout), .port_pullup_en(pull), .serial_shift_reg(sshift),
        .serial_slave_addr(sladdr), .serial_op_mode(smode), .serial_bus_control(sbus),
        .cpu_clock_select(cpuclk), .clock_out_mode(clkout));
    rsi_pin_model rsi_pin_model_inst (.clk(clk), .fire(fire), .low_len(low_len),
        .reset_pin_n(reset_pin_n));
    always #25 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    // Cycles since reset or the pin let go, frozen once the core runs
    always @(posedge clk) begin
        if (reset || !reset_pin_n) begin
            rel_cnt <= 0;
        end else if (!cpu_run) begin
            rel_cnt <= rel_cnt + 1;
        end
    end
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Width of each register by word index
    function automatic logic [31:0] msk(input int i);
        return (i inside {3, 4, 5, 6, 14, 15}) ? 32'hf : 32'hff;
    endfunction
    // Ends when cpu_run rises, with no timeout but the hang guard; the length is judged from release
    task automatic wait_run();
        while (cpu_run !== 1'b1) begin
            @(posedge clk);
        end
        chk(rel_cnt > WL && rel_cnt <= WL + 8, 1'b1, "wait length");
    endtask
    task automatic t_boot();
        wait_run();
        apb(0, `RSI_OFF_CTRL, 0);
        chk(rd, 32'hc, "boot status");
        for (int i = 1; i < 16; i++) begin
            apb(0, 8'(i * 4), 0);
            chk(rd, 0, "boot value");
        end
        apb(0, 8'h40, 0);
        chk(err, 1'b1, "unmapped read refused");
        chk(rd, 0, "unmapped read data");
        $display("test boot done");
    endtask
    task automatic t_irq();
        apb(1, `RSI_OFF_IRQ_EN, 32'hff);
        @(posedge clk);
        irq_event <= 8'h81;
        @(posedge clk);
        irq_event <= 8'h00;
        repeat (2) @(posedge clk);
        chk(irq_pending, 8'h81, "pending");
        apb(1, `RSI_OFF_IRQ_REQ, 32'h1);
        apb(0, `RSI_OFF_IRQ_REQ, 0);
        chk(rd, 32'h80, "clear one flag");
        $display("test irq done");
    endtask
    // Program words 2 to 15, pin reset with or without standby, check state
    task automatic t_reset(input logic stby);
        for (int i = 2; i < 16; i++) apb(1, 8'(i * 4), 32'ha5);
        chk(pen, 8'ha5, "direction out");
        apb(1, `RSI_OFF_CTRL, {31'h0, stby});
        @(posedge clk);
        fire <= 1'b1;
        low_len <= stby ? 8'd20 : 8'd6;
        @(posedge clk);
        fire <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1, `RSI_OFF_PRIO, 32'h3);
        chk(err, 1'b1, "write while held");
        wait_run();
        apb(0, `RSI_OFF_CTRL, 0);
        chk(rd, {28'h0, 2'b11, stby, 1'b0}, "status");
        for (int i = 1; i < 16; i++) begin
            apb(0, 8'(i * 4), 0);
            chk(rd, (stby && (i == 10 || i == 11)) ? 32'h5 & msk(i) | 32'ha0 : 0,
                "value after pin reset");
        end
        chk({pen, pout, pull, sladdr}, {24'h0, stby ? 8'ha5 : 8'h00}, "pins");
        chk({sshift, smode, sbus, prio, cpuclk}, {stby ? 8'ha5 : 8'h00, 24'h0},
            "core outputs");
        chk({em0, em1, em2, clkout}, 0, "edge and clock out");
        $display("test reset done");
    endtask
    initial begin
        clk = 0;
        reset = 1;
        {psel, penable, pwrite, fire} = 0;
        {paddr, pwdata, irq_event, low_len} = 0;
        repeat (3) @(posedge clk);
        reset <= 0;
        t_boot();
        t_irq();
        t_reset(1'b1);
        t_reset(1'b0);
        conclude();
    end
endmodule
